// ---- logic/cal_pkg.sv ----
// constants, types and register map of the arithmetic and logic datapath
// Notes on behaviour
// - add and subtract byte, word or longword, register or immediate source.
// - byte subtract with an immediate source is refused as illegal.
// - add_with_carry and subtract_with_borrow are byte only and fold in carry.
// - count_up and count_down step 1 or 2; byte steps by 1 only.
// - plus and minus_small_constant step a longword by 1, 2 or 4.
// - decimal adjust corrects a byte into two BCD digits using the flags.
// - unsigned_multiply gives 8x8 to 16 or 16x16 to 32 bits.
// - signed_multiply uses the same widths with two's complement operands.
// - unsigned_divide gives 16/8 and 32/16 quotient and remainder.
// - signed_divide uses the same widths with two's complement operands.
// - compare_op updates flags only; the destination stays unchanged.
// - negate replaces the operand with zero minus itself.
// - zero_extend widens byte to word or word to longword with zeros.
// - sign_extend widens the same fields copying the top bit.
// - test_and_set flags the byte against zero, then sets its bit 7.
// - multiply_accumulate adds a signed 16x16 product, saturating at 32 bit or wrapping at 42 bit.
// - accumulator_clear forces the whole accumulator to zero.
// - accumulator_load and accumulator_store move longwords to or from it.
// - AND, OR and XOR combine register with register or immediate.
// - NOT replaces the operand with its one's complement.
// - condition code flags N, Z, V, C follow results; carry feeds carry ops.
package cal_pkg;

  localparam logic [7:0]  CAL_OFF_OPA    = 8'h00;
  localparam logic [7:0]  CAL_OFF_OPB    = 8'h04;
  localparam logic [7:0]  CAL_OFF_CTRL   = 8'h08;
  localparam logic [7:0]  CAL_OFF_RESULT = 8'h0C;
  localparam logic [7:0]  CAL_OFF_COND   = 8'h10;
  localparam logic [7:0]  CAL_OFF_ACC_LO = 8'h14;
  localparam logic [7:0]  CAL_OFF_ACC_HI = 8'h18;
  localparam logic [7:0]  CAL_OFF_STATUS = 8'h1C;

  localparam int          CAL_GO_BIT     = 9;
  localparam int          CAL_ACC_W      = 42;
  localparam logic [31:0] CAL_RST_WORD   = 32'h0000_0000;
  localparam logic [41:0] CAL_RST_ACC    = 42'h000_0000_0000;
  localparam logic [31:0] CAL_SAT_MAX    = 32'h7FFF_FFFF;
  localparam logic [31:0] CAL_SAT_MIN    = 32'h8000_0000;
  localparam logic [31:0] CAL_BIT7       = 32'h0000_0080;

  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG, SZ_NONE} cal_size_type;

  typedef enum logic [4:0] {
    OP_ADD, OP_SUB, OP_ADD_CARRY, OP_SUB_BORROW, OP_COUNT_UP, OP_COUNT_DOWN,
    OP_PLUS_SMALL, OP_MINUS_SMALL, OP_ADJ_ADD, OP_ADJ_SUB, OP_MUL_U, OP_MUL_S,
    OP_DIV_U, OP_DIV_S, OP_COMPARE, OP_NEGATE, OP_ZERO_EXT, OP_SIGN_EXT,
    OP_TEST_SET, OP_ACC_MUL, OP_ACC_CLEAR, OP_ACC_LOAD_LO, OP_ACC_LOAD_HI,
    OP_ACC_STORE_LO, OP_ACC_STORE_HI, OP_AND, OP_OR, OP_XOR, OP_NOT
  } cal_op_type;

  // control word, bit 8 down to bit 0
  typedef struct packed {
    logic         sat;
    logic         imm;
    cal_size_type size;
    cal_op_type   op;
  } cal_ctrl_type;

  // condition codes, bit 4 down to bit 0
  typedef struct packed {
    logic h;
    logic n;
    logic z;
    logic v;
    logic c;
  } cal_flags_type;

  typedef struct packed {
    logic [31:0]   res;
    cal_flags_type fl;
  } cal_arith_type;

  localparam cal_ctrl_type  CAL_RST_CTRL = 9'h000;
  localparam cal_flags_type CAL_RST_COND = 5'h00;

endpackage

// ---- logic/cal_top.sv ----
// arithmetic and logic datapath with its apb register file
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/10ps
module cal_top
  import cal_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output wire logic [31:0] prdata,
  output wire logic        pready,
  output wire logic        pslverr
);

  logic [31:0]   opa_ff;
  logic [31:0]   opb_ff;
  cal_ctrl_type  ctrl_ff;
  logic          go_ff;
  logic [31:0]   res_ff;
  cal_flags_type cond_ff;
  logic [41:0]   acc_ff;
  logic          bad_ff;
  logic          div0_ff;
  logic          sat_ff;
  logic [31:0]   prdata_ff;
  logic          pready_ff;
  logic          pslverr_ff;

  logic [31:0]   nxt_res;
  cal_flags_type nxt_cond;
  logic [41:0]   nxt_acc;
  logic          nxt_sat;
  logic          op_bad;
  cal_arith_type ar;
  logic [31:0]   lg;
  logic [31:0]   rdata;

  // width helpers
  function automatic int top_bit(input cal_size_type sz);
    case (sz)
      SZ_BYTE: return 7;
      SZ_WORD: return 15;
      default: return 31;
    endcase
  endfunction

  function automatic logic [31:0] size_mask(input cal_size_type sz);
    case (sz)
      SZ_BYTE: return 32'h0000_00FF;
      SZ_WORD: return 32'h0000_FFFF;
      default: return 32'hFFFF_FFFF;
    endcase
  endfunction

  // add or subtract at the given size; upper bits of a pass through
  function automatic cal_arith_type arith(input logic [31:0] a,
                                          input logic [31:0] b,
                                          input logic sub,
                                          input logic ci,
                                          input cal_size_type sz,
                                          input cal_flags_type fin);
    cal_arith_type o;
    logic [31:0]   m;
    logic [31:0]   bb;
    logic [32:0]   s;
    logic [32:0]   hs;
    int            t;
    t = top_bit(sz);
    m = size_mask(sz);
    bb = sub ? ~b : b;
    // borrow is carried as inverted carry into the adder
    s = {1'b0, a & m} + {1'b0, bb & m} + {32'h0, ci ^ sub};
    hs = {1'b0, a & (m >> 4)} + {1'b0, bb & (m >> 4)} + {32'h0, ci ^ sub};
    o.res = (a & ~m) | (s[31:0] & m);
    o.fl = fin;
    o.fl.c = s[t+1] ^ sub;
    o.fl.h = hs[t-3] ^ sub;
    o.fl.n = s[t];
    o.fl.z = (s[31:0] & m) == 32'h0;
    o.fl.v = (a[t] == bb[t]) && (s[t] != a[t]);
    return o;
  endfunction

  function automatic cal_flags_type logic_flags(input logic [31:0] r,
                                                input cal_size_type sz,
                                                input cal_flags_type fin);
    cal_flags_type o;
    o = fin;
    o.n = r[top_bit(sz)];
    o.z = (r & size_mask(sz)) == 32'h0;
    o.v = 1'b0;
    return o;
  endfunction

  // operand and size decode
  wire          is_byte = ctrl_ff.size == SZ_BYTE;
  wire          is_word = ctrl_ff.size == SZ_WORD;
  wire          is_long = ctrl_ff.size == SZ_LONG;
  wire          is_none = ctrl_ff.size == SZ_NONE;
  wire [31:0]   szm     = size_mask(ctrl_ff.size);
  wire          step1   = opb_ff == 32'h1;
  wire          step2   = opb_ff == 32'h2;
  wire          step4   = opb_ff == 32'h4;
  wire          is_sdiv = ctrl_ff.op == OP_DIV_S;

  // multiplies
  wire [15:0]        mul_u8  = {8'h00, opa_ff[7:0]} * {8'h00, opb_ff[7:0]};
  wire [31:0]        mul_u16 = {16'h0, opa_ff[15:0]} * {16'h0, opb_ff[15:0]};
  wire signed [15:0] sa8     = {{8{opa_ff[7]}}, opa_ff[7:0]};
  wire signed [15:0] sb8     = {{8{opb_ff[7]}}, opb_ff[7:0]};
  wire signed [31:0] sa16    = {{16{opa_ff[15]}}, opa_ff[15:0]};
  wire signed [31:0] sb16    = {{16{opb_ff[15]}}, opb_ff[15:0]};
  wire signed [15:0] mul_s8  = sa8 * sb8;
  wire signed [31:0] mul_s16 = sa16 * sb16;

  // divides work on magnitudes, signs are restored afterwards
  wire [31:0] dvd     = is_byte ? {16'h0, opa_ff[15:0]} : opa_ff;
  wire [31:0] dvs     = is_byte ? {24'h0, opb_ff[7:0]} : {16'h0, opb_ff[15:0]};
  wire [31:0] dvd_m   = is_byte ? 32'h0000_FFFF : 32'hFFFF_FFFF;
  wire [31:0] dvs_m   = is_byte ? 32'h0000_00FF : 32'h0000_FFFF;
  wire        dvd_neg = is_sdiv & (is_byte ? opa_ff[15] : opa_ff[31]);
  wire        dvs_neg = is_sdiv & (is_byte ? opb_ff[7] : opb_ff[15]);
  wire [31:0] dvd_mag = dvd_neg ? ((~dvd + 32'h1) & dvd_m) : dvd;
  wire [31:0] dvs_mag = dvs_neg ? ((~dvs + 32'h1) & dvs_m) : dvs;
  wire        div0    = dvs == 32'h0;
  // a zero divisor is replaced so the divider never sees it
  wire [31:0] dvs_use = div0 ? 32'h1 : dvs_mag;
  wire [31:0] q_mag   = dvd_mag / dvs_use;
  wire [31:0] r_mag   = dvd_mag % dvs_use;
  wire [31:0] quo     = (dvd_neg ^ dvs_neg) ? (~q_mag + 32'h1) : q_mag;
  wire [31:0] rem     = dvd_neg ? (~r_mag + 32'h1) : r_mag;
  wire [31:0] div_res = is_byte ? {opa_ff[31:16], rem[7:0], quo[7:0]}
                                : {rem[15:0], quo[15:0]};

  // decimal adjust of the low byte
  wire [7:0] a8      = opa_ff[7:0];
  wire       daa_hi  = cond_ff.c | (a8 > 8'h99);
  wire       daa_lo  = cond_ff.h | (a8[3:0] > 4'h9);
  wire [7:0] daa_res = a8 + {1'b0, daa_hi, daa_hi, 2'b00, daa_lo, daa_lo, 1'b0};
  wire [7:0] das_res = a8 - {1'b0, cond_ff.c, cond_ff.c, 2'b00,
                             cond_ff.h, cond_ff.h, 1'b0};

  // accumulation
  wire signed [41:0] prod42 = {{10{mul_s16[31]}}, mul_s16};
  wire [41:0]        sum42  = acc_ff + prod42;
  wire [32:0]        sum33  = {acc_ff[31], acc_ff[31:0]} + {mul_s16[31], mul_s16};
  wire               ovf33  = sum33[32] != sum33[31];
  wire [31:0]        sat32  = ovf33 ? (sum33[32] ? CAL_SAT_MIN : CAL_SAT_MAX)
                                    : sum33[31:0];

  // legality of the requested operation and size
  always_comb begin
    op_bad = 1'b0;
    case (ctrl_ff.op)
      OP_ADD, OP_COMPARE, OP_NEGATE, OP_AND, OP_OR, OP_XOR, OP_NOT: begin
        op_bad = is_none;
      end
      OP_SUB: begin
        op_bad = is_none | (is_byte & ctrl_ff.imm);
      end
      OP_COUNT_UP, OP_COUNT_DOWN: begin
        op_bad = is_none | !(step1 | (step2 & !is_byte));
      end
      OP_PLUS_SMALL, OP_MINUS_SMALL: begin
        op_bad = !(step1 | step2 | step4);
      end
      OP_ADD_CARRY, OP_SUB_BORROW, OP_ADJ_ADD, OP_ADJ_SUB, OP_TEST_SET: begin
        op_bad = !is_byte;
      end
      OP_MUL_U, OP_MUL_S, OP_DIV_U, OP_DIV_S: begin
        op_bad = !(is_byte | is_word);
      end
      OP_ZERO_EXT, OP_SIGN_EXT: begin
        op_bad = !(is_word | is_long);
      end
      OP_ACC_MUL, OP_ACC_CLEAR, OP_ACC_LOAD_LO, OP_ACC_LOAD_HI,
      OP_ACC_STORE_LO, OP_ACC_STORE_HI: begin
        op_bad = 1'b0;
      end
      default: begin
        op_bad = 1'b1;
      end
    endcase
  end

  // execution of one operation
  always_comb begin
    nxt_res = res_ff;
    nxt_cond = cond_ff;
    nxt_acc = acc_ff;
    nxt_sat = 1'b0;
    ar = arith(opa_ff, opb_ff, ctrl_ff.op != OP_ADD, 1'b0,
               ctrl_ff.size, cond_ff);
    lg = 32'h0;
    if (go_ff && !op_bad) begin
      case (ctrl_ff.op)
        OP_ADD, OP_SUB: begin
          nxt_res = ar.res;
          nxt_cond = ar.fl;
        end
        OP_ADD_CARRY, OP_SUB_BORROW: begin
          ar = arith(opa_ff, opb_ff, ctrl_ff.op == OP_SUB_BORROW, cond_ff.c,
                     SZ_BYTE, cond_ff);
          nxt_res = ar.res;
          nxt_cond = ar.fl;
          // zero survives only across a chain of zero bytes
          nxt_cond.z = ar.fl.z & cond_ff.z;
        end
        OP_COUNT_UP, OP_COUNT_DOWN: begin
          ar = arith(opa_ff, opb_ff, ctrl_ff.op == OP_COUNT_DOWN, 1'b0,
                     ctrl_ff.size, cond_ff);
          nxt_res = ar.res;
          nxt_cond = ar.fl;
          nxt_cond.c = cond_ff.c;
          nxt_cond.h = cond_ff.h;
        end
        OP_PLUS_SMALL: begin
          nxt_res = opa_ff + opb_ff;
        end
        OP_MINUS_SMALL: begin
          nxt_res = opa_ff - opb_ff;
        end
        OP_ADJ_ADD: begin
          nxt_res = {opa_ff[31:8], daa_res};
          nxt_cond = logic_flags({24'h0, daa_res}, SZ_BYTE, cond_ff);
          nxt_cond.c = daa_hi;
        end
        OP_ADJ_SUB: begin
          nxt_res = {opa_ff[31:8], das_res};
          nxt_cond = logic_flags({24'h0, das_res}, SZ_BYTE, cond_ff);
        end
        OP_MUL_U: begin
          nxt_res = is_byte ? {opa_ff[31:16], mul_u8} : mul_u16;
        end
        OP_MUL_S: begin
          nxt_res = is_byte ? {opa_ff[31:16], mul_s8} : mul_s16;
          nxt_cond.n = is_byte ? mul_s8[15] : mul_s16[31];
          nxt_cond.z = is_byte ? (mul_s8 == 16'h0) : (mul_s16 == 32'h0);
        end
        OP_DIV_U, OP_DIV_S: begin
          nxt_res = div0 ? opa_ff : div_res;
          nxt_cond.z = div0;
          nxt_cond.n = is_sdiv ? (is_byte ? quo[7] : quo[15])
                               : (is_byte ? opb_ff[7] : opb_ff[15]);
        end
        OP_COMPARE: begin
          nxt_cond = ar.fl;
        end
        OP_NEGATE: begin
          ar = arith(32'h0, opa_ff, 1'b1, 1'b0, ctrl_ff.size, cond_ff);
          nxt_res = (opa_ff & ~szm) | (ar.res & szm);
          nxt_cond = ar.fl;
        end
        OP_ZERO_EXT: begin
          lg = is_word ? {opa_ff[31:16], 8'h00, opa_ff[7:0]}
                       : {16'h0000, opa_ff[15:0]};
          nxt_res = lg;
          nxt_cond = logic_flags(lg, ctrl_ff.size, cond_ff);
        end
        OP_SIGN_EXT: begin
          lg = is_word ? {opa_ff[31:16], {8{opa_ff[7]}}, opa_ff[7:0]}
                       : {{16{opa_ff[15]}}, opa_ff[15:0]};
          nxt_res = lg;
          nxt_cond = logic_flags(lg, ctrl_ff.size, cond_ff);
        end
        OP_TEST_SET: begin
          nxt_cond = logic_flags(opa_ff, SZ_BYTE, cond_ff);
          nxt_res = opa_ff | CAL_BIT7;
        end
        OP_ACC_MUL: begin
          nxt_acc = ctrl_ff.sat ? {{10{sat32[31]}}, sat32} : sum42;
          nxt_sat = ctrl_ff.sat & ovf33;
        end
        OP_ACC_CLEAR: begin
          nxt_acc = CAL_RST_ACC;
        end
        OP_ACC_LOAD_LO: begin
          nxt_acc = {acc_ff[41:32], opa_ff};
        end
        OP_ACC_LOAD_HI: begin
          nxt_acc = {opa_ff[9:0], acc_ff[31:0]};
        end
        OP_ACC_STORE_LO: begin
          nxt_res = acc_ff[31:0];
        end
        OP_ACC_STORE_HI: begin
          nxt_res = {{22{acc_ff[41]}}, acc_ff[41:32]};
        end
        OP_AND, OP_OR, OP_XOR, OP_NOT: begin
          case (ctrl_ff.op)
            OP_AND:  lg = opa_ff & opb_ff;
            OP_OR:   lg = opa_ff | opb_ff;
            OP_XOR:  lg = opa_ff ^ opb_ff;
            default: lg = ~opa_ff;
          endcase
          nxt_res = (opa_ff & ~szm) | (lg & szm);
          nxt_cond = logic_flags(lg, ctrl_ff.size, cond_ff);
        end
        default: begin
          nxt_res = res_ff;
        end
      endcase
    end
  end

  // apb decode
  wire hit_opa  = paddr == CAL_OFF_OPA;
  wire hit_opb  = paddr == CAL_OFF_OPB;
  wire hit_ctrl = paddr == CAL_OFF_CTRL;
  wire hit_res  = paddr == CAL_OFF_RESULT;
  wire hit_cond = paddr == CAL_OFF_COND;
  wire hit_alo  = paddr == CAL_OFF_ACC_LO;
  wire hit_ahi  = paddr == CAL_OFF_ACC_HI;
  wire hit_stat = paddr == CAL_OFF_STATUS;
  wire mapped   = hit_opa | hit_opb | hit_ctrl | hit_res | hit_cond |
                  hit_alo | hit_ahi | hit_stat;
  // ready is held back while an operation lands, so reads never see stale data
  wire answer   = psel & !pready_ff & !go_ff;
  wire wr       = psel & penable & pready_ff & pwrite & mapped;

  assign rdata = hit_opa  ? opa_ff :
                 hit_opb  ? opb_ff :
                 hit_ctrl ? {23'h0, ctrl_ff} :
                 hit_res  ? res_ff :
                 hit_cond ? {27'h0, cond_ff} :
                 hit_alo  ? acc_ff[31:0] :
                 hit_ahi  ? {22'h0, acc_ff[41:32]} :
                 hit_stat ? {28'h0, sat_ff, div0_ff, bad_ff, go_ff} :
                 32'h0;

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= CAL_RST_WORD;
    end else begin
      pready_ff <= answer;
      pslverr_ff <= answer & !mapped;
      prdata_ff <= answer ? rdata : prdata_ff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opa_ff <= CAL_RST_WORD;
      opb_ff <= CAL_RST_WORD;
      ctrl_ff <= CAL_RST_CTRL;
      go_ff <= 1'b0;
    end else begin
      opa_ff <= (wr & hit_opa) ? pwdata : opa_ff;
      opb_ff <= (wr & hit_opb) ? pwdata : opb_ff;
      ctrl_ff <= (wr & hit_ctrl) ? cal_ctrl_type'(pwdata[8:0]) : ctrl_ff;
      go_ff <= wr & hit_ctrl & pwdata[CAL_GO_BIT];
    end
  end

  // an operation's flag update wins over a software write in the same cycle
  wire cond_sw = wr & hit_cond & !go_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_ff <= CAL_RST_WORD;
      cond_ff <= CAL_RST_COND;
      acc_ff <= CAL_RST_ACC;
      bad_ff <= 1'b0;
      div0_ff <= 1'b0;
      sat_ff <= 1'b0;
    end else begin
      res_ff <= nxt_res;
      cond_ff <= cond_sw ? cal_flags_type'(pwdata[4:0]) : nxt_cond;
      acc_ff <= nxt_acc;
      if (go_ff) begin
        bad_ff <= op_bad;
        div0_ff <= !op_bad & div0 &
                   (ctrl_ff.op == OP_DIV_U | ctrl_ff.op == OP_DIV_S);
        sat_ff <= nxt_sat;
      end
    end
  end

  // checks
  AST_READY_AFTER_SETUP: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !go_ff && !pready_ff |=> pready && prdata == $past(rdata))
    else $error("ready or read data missing after setup");
  AST_SUB_IMM_BYTE: assert property (@(posedge pclk) disable iff (!presetn)
    go_ff && ctrl_ff.op == OP_SUB && is_byte && ctrl_ff.imm
    |=> bad_ff && $stable(res_ff) && $stable(cond_ff))
    else $error("byte subtract of immediate was not refused");
  AST_ADD_CARRY: assert property (@(posedge pclk) disable iff (!presetn)
    go_ff && ctrl_ff.op == OP_ADD_CARRY && is_byte
    |=> res_ff[7:0] == 8'($past(opa_ff[7:0]) + $past(opb_ff[7:0])
                        + {7'h0, $past(cond_ff.c)}))
    else $error("add with carry result wrong");
  AST_COMPARE_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
    go_ff && ctrl_ff.op == OP_COMPARE && !op_bad
    |=> $stable(res_ff) && cond_ff.z == ($past(opa_ff & szm) == $past(opb_ff & szm)))
    else $error("compare changed destination or zero flag wrong");
  AST_ZERO_EXT_LONG: assert property (@(posedge pclk) disable iff (!presetn)
    go_ff && ctrl_ff.op == OP_ZERO_EXT && is_long
    |=> res_ff == {16'h0000, $past(opa_ff[15:0])} && !cond_ff.n)
    else $error("zero extension wrong");
  AST_TEST_SET_BIT7: assert property (@(posedge pclk) disable iff (!presetn)
    go_ff && ctrl_ff.op == OP_TEST_SET && is_byte
    |=> res_ff[7] && cond_ff.z == ($past(opa_ff[7:0]) == 8'h00))
    else $error("test and set wrong");
  AST_ACC_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
    go_ff && ctrl_ff.op == OP_ACC_CLEAR |=> acc_ff == CAL_RST_ACC)
    else $error("accumulator not cleared");
  AST_SAT_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
    go_ff && ctrl_ff.op == OP_ACC_MUL && ctrl_ff.sat
    |=> acc_ff[41:31] == {11{acc_ff[41]}})
    else $error("saturating accumulation left 32 bit range");
  AST_NOT_LONG: assert property (@(posedge pclk) disable iff (!presetn)
    go_ff && ctrl_ff.op == OP_NOT && is_long |=> res_ff == ~$past(opa_ff))
    else $error("not result wrong");
  AST_DIV_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    go_ff && ctrl_ff.op == OP_DIV_U && !op_bad && div0
    |=> div0_ff && cond_ff.z && res_ff == $past(opa_ff) ##1 !go_ff)
    else $error("divide by zero not handled");

endmodule

// ---- testbench/cal_apb_master.sv ----
// apb master standing in for the decoder and register file side
`timescale 1ns/10ps
module cal_apb_master (
  // clock
  input  wire logic        pclk,
  // apb request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  // apb answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h00000000;
  end

  // operands arrive as the decoder hands them over
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // released lines must not keep looking valid
    paddr   <= ~a;
    pwdata  <= ~d;
    @(posedge pclk);
  endtask
endmodule

// ---- testbench/cal_top_tb.sv ----
// self-checking bench of the datapath, driven over apb
`timescale 1ns/10ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
  fails++; $display("wrong value at %0t: %h not %h", $time, got, exp); \
  end end
module cal_top_tb
  import cal_pkg::*;
;
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  localparam logic [7:0]  RES = CAL_OFF_RESULT;
  localparam logic [7:0]  CND = CAL_OFF_COND;
  localparam logic [7:0]  STS = CAL_OFF_STATUS;
  localparam logic [7:0]  ALO = CAL_OFF_ACC_LO;
  localparam logic [7:0]  AHI = CAL_OFF_ACC_HI;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] q;
  logic        er;
  int          fails;
  int          comparisons;
  int          cyc;

  cal_top i_cal_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  cal_apb_master i_apb (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  always #5 pclk = ~pclk;

  task automatic close_out();
    if (fails == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // a few hundred transfers at most; far beyond that means a hang
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 8000) begin
      fails++;
      close_out();
    end
  end

  task automatic rd(input logic [7:0] a);
    i_apb.xfer(1'b0, a, 32'h00000000, q, er);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_apb.xfer(1'b1, a, d, q, er);
  endtask

  // operands, flags, launch, then one masked read-back
  task automatic t(cal_op_type o, cal_size_type s, logic [1:0] si,
                   logic [31:0] a, logic [31:0] b, logic [4:0] f,
                   logic [7:0] ad, logic [31:0] m, logic [31:0] e);
    wr(CAL_OFF_OPA, a);
    wr(CAL_OFF_OPB, b);
    wr(CND, {27'h0000000, f});
    wr(CAL_OFF_CTRL, {22'h000000, 1'b1, si, s, o});
    rd(ad);
    `CHK(q & m, e)
  endtask

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int k = 0; k < 8; k++) begin
      rd(8'(k * 4));
      `CHK({er, q}, {1'b0, CAL_RST_WORD})
    end
    wr(RES, ALL);
    rd(RES);
    `CHK(q, CAL_RST_WORD)
    rd(8'h20);
    `CHK({er, q}, 33'h100000000)
    t(OP_ADD, SZ_WORD, 0, 32'h1234, 32'hF0F, 0, RES, ALL, 32'h2143);
    t(OP_ADD, SZ_LONG, 0, ALL, 32'h1, 0, CND, 32'hF, 32'h5);
    t(OP_SUB, SZ_WORD, 1, 32'h1000, 32'h1, 0, RES, ALL, 32'hFFF);
    t(OP_SUB, SZ_BYTE, 1, 32'h10, 32'h1, 0, STS, 32'h2, 32'h2);
    t(OP_ADD_CARRY, SZ_BYTE, 1, 32'hFF, 32'h0, 1, RES, ALL, 32'h0);
    t(OP_SUB_BORROW, SZ_BYTE, 0, 32'h10, 32'h1, 1, RES, ALL, 32'hE);
    t(OP_ADD_CARRY, SZ_WORD, 0, 32'h1, 32'h1, 0, STS, 32'h2, 32'h2);
    t(OP_COUNT_UP, SZ_BYTE, 0, 32'hFF, 32'h1, 0, RES, ALL, 32'h0);
    t(OP_COUNT_UP, SZ_BYTE, 0, 32'h0, 32'h2, 0, STS, 32'h2, 32'h2);
    t(OP_COUNT_DOWN, SZ_WORD, 0, 32'h10001, 32'h2, 0, RES, ALL, 32'h1FFFF);
    t(OP_PLUS_SMALL, SZ_LONG, 0, 32'hFFFFFFFC, 32'h4, 0, RES, ALL, 0);
    t(OP_MINUS_SMALL, SZ_LONG, 0, 32'h2, 32'h4, 0, RES, ALL, ALL - 1);
    t(OP_PLUS_SMALL, SZ_LONG, 0, 32'h0, 32'h3, 0, STS, 32'h2, 32'h2);
    t(OP_ADJ_ADD, SZ_BYTE, 0, 32'hA, 32'h0, 0, RES, ALL, 32'h10);
    t(OP_ADJ_SUB, SZ_BYTE, 0, 32'h1F, 32'h0, 5'h10, RES, ALL, 32'h19);
    t(OP_MUL_U, SZ_BYTE, 0, 32'hFF, 32'hFF, 0, RES, ALL, 32'hFE01);
    t(OP_MUL_U, SZ_WORD, 0, 32'hFFFF, 32'hFFFF, 0, RES, ALL, 32'hFFFE0001);
    t(OP_MUL_S, SZ_BYTE, 0, 32'hFF, 32'h2, 0, RES, ALL, 32'hFFFE);
    t(OP_MUL_S, SZ_WORD, 0, 32'hFFFF, 32'h2, 0, RES, ALL, ALL - 1);
    t(OP_DIV_U, SZ_BYTE, 0, 32'h64, 32'h7, 0, RES, ALL, 32'h20E);
    t(OP_DIV_U, SZ_WORD, 0, 32'h10000, 32'h2, 0, RES, ALL, 32'h8000);
    t(OP_DIV_S, SZ_WORD, 0, ALL - 6, 32'h2, 0, RES, ALL, ALL - 2);
    t(OP_DIV_S, SZ_BYTE, 0, 32'hFFF9, 32'h2, 0, RES, ALL, 32'hFFFD);
    t(OP_DIV_U, SZ_WORD, 0, 32'h1234, 32'h0, 0, STS, 32'h4, 32'h4);
    t(OP_DIV_U, SZ_WORD, 0, 32'h1234, 32'h0, 0, RES, ALL, 32'h1234);
    t(OP_COMPARE, SZ_LONG, 0, 32'h5, 32'h5, 0, CND, 32'h4, 32'h4);
    t(OP_COMPARE, SZ_WORD, 0, 32'h1234, 32'h1, 0, RES, ALL, 32'h1234);
    t(OP_NEGATE, SZ_BYTE, 0, 32'h1, 32'h0, 0, RES, ALL, 32'hFF);
    t(OP_ZERO_EXT, SZ_WORD, 0, 32'h12345680, 0, 0, RES, ALL, 32'h12340080);
    t(OP_SIGN_EXT, SZ_LONG, 0, 32'h8000, 32'h0, 0, RES, ALL, 32'hFFFF8000);
    t(OP_TEST_SET, SZ_BYTE, 0, 32'h1, 32'h0, 0, RES, ALL, 32'h81);
    t(OP_TEST_SET, SZ_BYTE, 0, 32'h0, 32'h0, 0, CND, 32'h4, 32'h4);
    t(OP_AND, SZ_LONG, 1, 32'hF0F0F0F0, 32'hFF00FF00, 0, RES, ALL, 32'hF000F000);
    t(OP_OR, SZ_WORD, 0, 32'h12340000, 32'hFF, 0, RES, ALL, 32'h123400FF);
    t(OP_XOR, SZ_BYTE, 1, 32'hAA, 32'hFF, 0, RES, ALL, 32'h55);
    t(OP_NOT, SZ_LONG, 0, 32'hF0F0F0F, 32'h0, 0, RES, ALL, 32'hF0F0F0F0);
    t(OP_ACC_LOAD_LO, SZ_LONG, 0, 32'h7FFFFFF0, 0, 0, ALO, ALL, 32'h7FFFFFF0);
    t(OP_ACC_LOAD_HI, SZ_LONG, 0, 32'h0, 32'h0, 0, AHI, ALL, 32'h0);
    t(OP_ACC_MUL, SZ_WORD, 2, 32'h100, 32'h100, 0, ALO, ALL, CAL_SAT_MAX);
    rd(STS);
    `CHK(q, 32'h8)
    t(OP_ACC_STORE_LO, SZ_LONG, 0, 32'h0, 32'h0, 0, RES, ALL, CAL_SAT_MAX);
    t(OP_ACC_MUL, SZ_WORD, 0, 32'h100, 32'h100, 0, ALO, ALL, 32'h8000FFFF);
    t(OP_ACC_STORE_HI, SZ_LONG, 0, 32'h0, 32'h0, 0, RES, ALL, 32'h0);
    t(OP_ACC_LOAD_HI, SZ_LONG, 0, 32'h3FF, 32'h0, 0, AHI, ALL, 32'h3FF);
    t(OP_ACC_CLEAR, SZ_LONG, 0, 32'h0, 32'h0, 0, AHI, ALL, 32'h0);
    t(OP_ACC_MUL, SZ_WORD, 0, 32'hFFFF, 32'h2, 0, AHI, ALL, 32'h3FF);
    t(OP_NOT, SZ_BYTE, 0, 32'h0, 32'h0, 0, CAL_OFF_CTRL, 32'h200, 0);
    close_out();
  end
endmodule
